/* hw/rpbs_pkg.sv */
// Constants and types shared by the reset and power sequencer
package rpbs_pkg;
  // Core clock rate
  localparam int unsigned CLK_HZ = 50000000;
  // Button hold time for regulator start, microseconds
  localparam int unsigned START_HOLD_US = 1000;
  localparam int unsigned START_HOLD_CYC = (CLK_HZ / 1000000) * START_HOLD_US;
  // Long-press reset time, milliseconds
  localparam int unsigned LONG_PRESS_MS = 5600;
  localparam longint unsigned LONG_PRESS_CYC =
    (64'(CLK_HZ) / 64'd1000) * 64'(LONG_PRESS_MS);
  // Reset stretch after the last source falls, cycles
  localparam int unsigned RST_STRETCH_CYC = 16;
  // Register indices on the plain register port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_VCORE = 4'h2;
  localparam logic [3:0] REG_VIO = 4'h3;
  localparam logic [3:0] REG_VANA = 4'h4;
  localparam logic [3:0] REG_CLK = 4'h5;
  localparam logic [3:0] REG_SHUTDOWN = 4'h6;
  // Control register fields
  localparam int unsigned CTRL_LP_DIS_BIT = 0;
  localparam int unsigned CTRL_USB_SUSP_BIT = 1;
  // Status register fields
  localparam int unsigned ST_BUTTON_BIT = 0;
  localparam int unsigned ST_REG_ON_BIT = 1;
  localparam int unsigned ST_CLK_RTC_BIT = 2;
  localparam int unsigned ST_CAUSE_LSB = 8;
  // Shutdown key: both bits must be written together
  localparam logic [1:0] SHUTDOWN_KEY = 2'h3;
  // Regulator defaults
  localparam logic [7:0] VCORE_DEF = 8'h40;
  localparam logic [7:0] VIO_DEF_1V8 = 8'h12;
  localparam logic [7:0] VANA_DEF = 8'h60;
  // PLL multiplier code: factor = 1.0 + 0.5 * code, codes 0..14
  localparam logic [3:0] PLL_MULT_DEF = 4'h0;
  localparam logic [3:0] PLL_MULT_MAX = 4'he;
  // Reset cause encoding
  typedef enum logic [2:0] {
    RPBS_CAUSE_NONE,
    RPBS_CAUSE_POR,
    RPBS_CAUSE_PIN,
    RPBS_CAUSE_WDOG,
    RPBS_CAUSE_DBG,
    RPBS_CAUSE_BUTTON
  } rpbs_cause_e;
endpackage

/* hw/rpbs_sync.sv */
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
module rpbs_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;

  // Only the second flop is read downstream
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

/* hw/rpbs_hold_timer.sv */
// Counts cycles a level stays high and flags when a limit is passed
`timescale 1ns/10ps
module rpbs_hold_timer #(
  parameter int unsigned WIDTH = 32,
  parameter logic [WIDTH-1:0] LIMIT = '1
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic level_in,
  output logic done_out
);
  logic [WIDTH-1:0] count_q;

  // Restart on any drop; saturate once limit reached
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_q <= '0;
      done_out <= 1'b0;
    end else if (!level_in) begin
      count_q <= '0;
      done_out <= 1'b0;
    end else if (count_q >= LIMIT) begin
      done_out <= 1'b1;
    end else begin
      count_q <= count_q + WIDTH'(1);
    end
  end
endmodule

/* hw/rpbs_top.sv */
// Reset merge, regulator latch and clock selection for the core
// Function
// - Power-on, pin, watchdog, debugger and long-press sources merge into one reset.
// - Holding the button beyond 5.6 s forces a reset.
// - A software bit disables the long-press reset.
// - A low core supply reading asserts power-on reset.
// - Regulators start once the button is held about 1 ms.
// - Regulators stay latched on after the button is released.
// - Any reset keeps regulators on but reloads default voltages.
// - Software may change the regulator voltages after boot.
// - Only a software shutdown write turns the regulators off.
// - The button level is readable by software.
// - The external reset pin gates the clock buffer and powers down logic.
// - USB suspend moves the core clock to RTC and stops the oscillator.
// - The PLL multiplier runs 1.0x to 8.0x in half steps.
// - Main oscillator and 32 kHz RTC clock are the two sources.
// - Digital I/O voltage defaults to 1.8 V after reset.
// - Power-on, pin or watchdog reset restarts the processor boot.
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/10ps
module rpbs_top
  import rpbs_pkg::*;
#(
  parameter longint unsigned LONG_PRESS_CYCLES = LONG_PRESS_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic power_button_in,
  input wire logic external_reset_n_in,
  input wire logic core_voltage_threshold_in,
  input wire logic wdog_rst_in,
  input wire logic dbg_rst_in,
  input wire logic usb_suspend_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  output logic sys_rst_n_out,
  output logic boot_restart_out,
  output logic regulator_en_out,
  output logic [7:0] vcore_set_out,
  output logic [7:0] vio_set_out,
  output logic [7:0] vana_set_out,
  output logic [3:0] pll_mult_out,
  output logic clk_sel_rtc_out,
  output logic osc_pd_out,
  output logic clk_buf_en_out,
  output logic digital_pd_out
);
  logic button_s;
  logic ext_rst_n_s;
  logic core_low_s;
  logic wdog_s;
  logic dbg_s;
  logic usb_susp_s;
  logic start_done;
  logic long_done;
  logic lp_dis_q;
  logic usb_susp_en_q;
  logic reg_on_q;
  logic [7:0] vcore_q;
  logic [7:0] vio_q;
  logic [7:0] vana_q;
  logic [3:0] pll_q;
  logic any_src;
  logic boot_src;
  logic [4:0] stretch_q;
  logic rst_q;
  logic rst_prev_q;
  logic boot_pend_q;
  rpbs_cause_e cause_q;
  logic [15:0] rdata_d;

  // Every pin level is synchronised before use
  rpbs_sync u_sync_btn (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .async_in(power_button_in),
    .sync_out(button_s)
  );
  // Pin flops reset released; monitor flops reset to low supply
  rpbs_sync #(.RST_VAL(1'b1)) u_sync_xrst (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .async_in(external_reset_n_in),
    .sync_out(ext_rst_n_s)
  );
  rpbs_sync #(.RST_VAL(1'b1)) u_sync_core_voltage_threshold (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .async_in(core_voltage_threshold_in),
    .sync_out(core_low_s)
  );
  rpbs_sync u_sync_wdog (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .async_in(wdog_rst_in),
    .sync_out(wdog_s)
  );
  rpbs_sync u_sync_dbg (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .async_in(dbg_rst_in),
    .sync_out(dbg_s)
  );
  rpbs_sync u_sync_usb (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .async_in(usb_suspend_in),
    .sync_out(usb_susp_s)
  );

  // Button hold for regulator start
  rpbs_hold_timer #(.WIDTH(32), .LIMIT(32'(START_HOLD_CYC))) u_start (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .level_in(button_s),
    .done_out(start_done)
  );

  // Long press, gated by the software disable bit
  rpbs_hold_timer #(.WIDTH(64), .LIMIT(64'(LONG_PRESS_CYCLES))) u_long (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .level_in(button_s && !lp_dis_q),
    .done_out(long_done)
  );

  // Merge of all reset sources; core_low_s high means below threshold
  assign any_src = core_low_s || !ext_rst_n_s || wdog_s || dbg_s ||
                   long_done;
  // Debugger reset does not rerun boot
  assign boot_src = core_low_s || !ext_rst_n_s || wdog_s || long_done;

  // Stretch and release on a clock edge so all logic leaves together
  // A source that flickers restarts the full stretch
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stretch_q <= 5'(RST_STRETCH_CYC);
      rst_q <= 1'b1;
    end else if (any_src) begin
      stretch_q <= 5'(RST_STRETCH_CYC);
      rst_q <= 1'b1;
    end else if (stretch_q != 5'h00) begin
      stretch_q <= stretch_q - 5'h01;
    end else begin
      rst_q <= 1'b0;
    end
  end

  // Record the cause of the latest reset
  // Highest-priority active source wins when several overlap
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cause_q <= RPBS_CAUSE_POR;
    end else if (core_low_s) begin
      cause_q <= RPBS_CAUSE_POR;
    end else if (!ext_rst_n_s) begin
      cause_q <= RPBS_CAUSE_PIN;
    end else if (wdog_s) begin
      cause_q <= RPBS_CAUSE_WDOG;
    end else if (dbg_s) begin
      cause_q <= RPBS_CAUSE_DBG;
    end else if (long_done) begin
      cause_q <= RPBS_CAUSE_BUTTON;
    end
  end

  // Boot pulse on release of a boot-class reset
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_prev_q <= 1'b1;
      boot_restart_out <= 1'b0;
    end else begin
      rst_prev_q <= rst_q;
      boot_restart_out <= rst_prev_q && !rst_q && boot_pend_q;
    end
  end

  // Boot request survives a later debugger reset in the same stretch
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      boot_pend_q <= 1'b1;
    end else if (boot_src) begin
      boot_pend_q <= 1'b1;
    end else if (rst_prev_q && !rst_q) begin
      boot_pend_q <= 1'b0;
    end
  end

  // Regulator latch: only a shutdown write clears it
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_on_q <= 1'b0;
    end else if (start_done) begin
      reg_on_q <= 1'b1;
    end else if (reg_wr_in && !rst_q && reg_addr_in == REG_SHUTDOWN &&
                 reg_wdata_in[1:0] == SHUTDOWN_KEY) begin
      reg_on_q <= 1'b0;
    end
  end

  // Voltage settings reload on any internal reset
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vcore_q <= VCORE_DEF;
      vio_q <= VIO_DEF_1V8;
      vana_q <= VANA_DEF;
    end else if (rst_q) begin
      vcore_q <= VCORE_DEF;
      vio_q <= VIO_DEF_1V8;
      vana_q <= VANA_DEF;
    end else if (reg_wr_in) begin
      if (reg_addr_in == REG_VCORE) begin
        vcore_q <= reg_wdata_in[7:0];
      end
      if (reg_addr_in == REG_VIO) begin
        vio_q <= reg_wdata_in[7:0];
      end
      if (reg_addr_in == REG_VANA) begin
        vana_q <= reg_wdata_in[7:0];
      end
    end
  end

  // Control bits and PLL multiplier; out-of-range codes are ignored
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lp_dis_q <= 1'b0;
      usb_susp_en_q <= 1'b1;
      pll_q <= PLL_MULT_DEF;
    end else if (rst_q) begin
      lp_dis_q <= 1'b0;
      usb_susp_en_q <= 1'b1;
      pll_q <= PLL_MULT_DEF;
    end else if (reg_wr_in && reg_addr_in == REG_CTRL) begin
      lp_dis_q <= reg_wdata_in[CTRL_LP_DIS_BIT];
      usb_susp_en_q <= reg_wdata_in[CTRL_USB_SUSP_BIT];
    end else if (reg_wr_in && reg_addr_in == REG_CLK &&
                 reg_wdata_in[3:0] <= PLL_MULT_MAX) begin
      pll_q <= reg_wdata_in[3:0];
    end
  end

  // Clock source selection: main oscillator or RTC in suspend
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_sel_rtc_out <= 1'b0;
      osc_pd_out <= 1'b0;
      clk_buf_en_out <= 1'b0;
      digital_pd_out <= 1'b1;
    end else begin
      clk_sel_rtc_out <= usb_susp_s && usb_susp_en_q;
      osc_pd_out <= usb_susp_s && usb_susp_en_q;
      clk_buf_en_out <= ext_rst_n_s;
      digital_pd_out <= !ext_rst_n_s;
    end
  end

  // Read mux; unmapped indices read zero
  always_comb begin
    rdata_d = 16'h0000;
    case (reg_addr_in)
      REG_CTRL: begin
        rdata_d[CTRL_LP_DIS_BIT] = lp_dis_q;
        rdata_d[CTRL_USB_SUSP_BIT] = usb_susp_en_q;
      end
      REG_STATUS: begin
        rdata_d[ST_BUTTON_BIT] = button_s;
        rdata_d[ST_REG_ON_BIT] = reg_on_q;
        rdata_d[ST_CLK_RTC_BIT] = clk_sel_rtc_out;
        rdata_d[ST_CAUSE_LSB +: 3] = cause_q;
      end
      REG_VCORE: rdata_d[7:0] = vcore_q;
      REG_VIO: rdata_d[7:0] = vio_q;
      REG_VANA: rdata_d[7:0] = vana_q;
      REG_CLK: rdata_d[3:0] = pll_q;
      default: rdata_d = 16'h0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_d;
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

  // Regulated outputs come straight from the latches
  assign sys_rst_n_out = !rst_q;
  assign regulator_en_out = reg_on_q;
  assign vcore_set_out = vcore_q;
  assign vio_set_out = vio_q;
  assign vana_set_out = vana_q;
  assign pll_mult_out = pll_q;
endmodule

/* dv/rpbs_asserts.sv */
// Port checker for the reset and power sequencer
`timescale 1ns/10ps
module rpbs_asserts
  import rpbs_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic power_button_in,
  input wire logic external_reset_n_in,
  input wire logic core_voltage_threshold_in,
  input wire logic wdog_rst_in,
  input wire logic dbg_rst_in,
  input wire logic usb_suspend_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic sys_rst_n_out,
  input wire logic regulator_en_out,
  input wire logic [7:0] vcore_set_out,
  input wire logic [7:0] vio_set_out,
  input wire logic [3:0] pll_mult_out,
  input wire logic clk_sel_rtc_out,
  input wire logic osc_pd_out,
  input wire logic clk_buf_en_out,
  input wire logic digital_pd_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // Sources pass two sync flops, so allow a few edges
  a_pin_gates_clock: assert property ($fell(external_reset_n_in) |->
    ##[1:4] (!clk_buf_en_out && digital_pd_out)) else $error("pin gating");
  a_source_resets: assert property ((core_voltage_threshold_in ||
    wdog_rst_in || dbg_rst_in || !external_reset_n_in) [*5]
    |-> !sys_rst_n_out) else $error("source not merged");
  a_release_stretch: assert property ($rose(sys_rst_n_out) |->
    !$past(sys_rst_n_out, 15)) else $error("release too soon");
  a_default_reload: assert property ($rose(sys_rst_n_out) |->
    vio_set_out == VIO_DEF_1V8 && vcore_set_out == VCORE_DEF)
    else $error("defaults not reloaded");
  a_off_by_write: assert property ($fell(regulator_en_out) |->
    $past(reg_wr_in) && $past(reg_addr_in) == REG_SHUTDOWN)
    else $error("regulator off without write");
  a_start_held: assert property ($rose(regulator_en_out) |->
    $past(power_button_in, 1000)) else $error("start too early");
  a_pll_in_range: assert property (pll_mult_out <= PLL_MULT_MAX)
    else $error("pll code out of range");
  a_suspend_rtc: assert property ((sys_rst_n_out && usb_suspend_in) [*5]
    |-> clk_sel_rtc_out && osc_pd_out) else $error("suspend clocking");
  // Main scenarios
  c_reg_on: cover property ($rose(regulator_en_out));
  c_reset: cover property ($fell(sys_rst_n_out));
  c_rtc: cover property ($rose(clk_sel_rtc_out));
endmodule

/* dv/rpbs_ext_model.sv */
// Button, reset pin and supply monitor outside the sequencer
`timescale 1ns/10ps
module rpbs_ext_model (
  input wire logic mclk_in,
  output logic button_out,
  output logic pin_n_out,
  output logic core_low_out
);
  // Idle: button up, pin released, supply good
  initial begin
    button_out = 1'b0;
    pin_n_out = 1'b1;
    core_low_out = 1'b0;
  end
  // One source active n cycles: 0 button, 1 pin, 2 low supply
  task automatic hold(input int k, input int n);
    @(posedge mclk_in);
    button_out <= (k == 0);
    pin_n_out <= (k != 1);
    core_low_out <= (k == 2);
    repeat (n) @(posedge mclk_in);
    button_out <= 1'b0;
    pin_n_out <= 1'b1;
    core_low_out <= 1'b0;
  endtask
endmodule

/* dv/testbench.sv */
// Register-level tests of the reset and power sequencer
`timescale 1ns/10ps
module testbench
  import rpbs_pkg::*;
();
  logic mclk_in, rst_n_in, wdog_rst_in, dbg_rst_in, usb_suspend_in;
  logic power_button_in, external_reset_n_in, core_voltage_threshold_in;
  logic reg_wr_in, reg_rd_in, sys_rst_n_out, boot_restart_out;
  logic regulator_en_out, clk_sel_rtc_out, osc_pd_out;
  logic clk_buf_en_out, digital_pd_out;
  logic [3:0] reg_addr_in, pll_mult_out;
  logic [15:0] reg_wdata_in, reg_rdata_out, d;
  logic [7:0] vcore_set_out, vio_set_out, vana_set_out;
  logic [2:0] cz [5] = '{3'h5, 3'h2, 3'h1, 3'h3, 3'h4};
  int n_fail, total_checks, bc, b;
  // Short long-press limit keeps the run brief
  rpbs_top #(.LONG_PRESS_CYCLES(200)) i_rpbs_top (.*);
  rpbs_ext_model i_rpbs_ext_model (.mclk_in(mclk_in),
    .button_out(power_button_in), .pin_n_out(external_reset_n_in),
    .core_low_out(core_voltage_threshold_in));
  // Clock, 20 ns period
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  // Boot restart pulses
  always @(posedge mclk_in) if (boot_restart_out === 1'b1) bc <= bc + 1;
  task automatic chk(input logic [15:0] g, e, input string m);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
    @(negedge mclk_in);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    @(negedge mclk_in);
    q = reg_rdata_out;
  endtask
  // Wait, bounded, until the internal reset lets go
  task automatic wait_rel();
    int i;
    i = 0;
    while (sys_rst_n_out !== 1'b1 && i < 300) begin
      @(posedge mclk_in);
      i++;
    end
    chk(16'(sys_rst_n_out), 16'h1, "release");
  endtask
  // Sources 3 and 4 are watchdog and debugger, the rest in the model
  task automatic src(input int k, input int n);
    if (k < 3) i_rpbs_ext_model.hold(k, n);
    else begin
      @(posedge mclk_in);
      wdog_rst_in <= (k == 3);
      dbg_rst_in <= (k == 4);
      repeat (n) @(posedge mclk_in);
      wdog_rst_in <= 1'b0;
      dbg_rst_in <= 1'b0;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    int k;
    {rst_n_in, wdog_rst_in, dbg_rst_in, usb_suspend_in} = 4'h0;
    {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = 22'h0;
    {n_fail, total_checks} = '0;
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    wait_rel();
    rd(REG_VIO, d);
    chk(d, 16'(VIO_DEF_1V8), "vio default");
    chk(16'(vio_set_out), 16'(VIO_DEF_1V8), "vio pin default");
    rd(4'hf, d);
    chk(d, 16'h0, "unmapped read");
    $display("test defaults done");
    // Long press off, then a start-length press
    wr(REG_CTRL, 16'h3);
    fork i_rpbs_ext_model.hold(0, 50100); join_none
    repeat (100) @(posedge mclk_in);
    rd(REG_STATUS, d);
    chk(16'(d[ST_BUTTON_BIT]), 16'h1, "button level");
    repeat (START_HOLD_CYC - 110) @(posedge mclk_in);
    chk(16'(regulator_en_out), 16'h0, "start early");
    repeat (210) @(posedge mclk_in);
    chk(16'(regulator_en_out), 16'h1, "latched on");
    chk(16'(sys_rst_n_out), 16'h1, "press reset");
    rd(REG_STATUS, d);
    chk(16'(d[ST_BUTTON_BIT]), 16'h0, "button up");
    $display("test start done");
    // Each source in turn; button last, once CTRL is back at default
    for (int j = 1; j < 6; j++) begin
      k = j % 5;
      wr(REG_VCORE, 16'h55);
      chk(16'(vcore_set_out), 16'h55, "vcore write");
      wr(REG_VANA, 16'h21);
      chk(16'(vana_set_out), 16'h21, "vana write");
      b = bc;
      src(k, (k == 0) ? 300 : 10);
      if (k == 1) chk(16'({clk_buf_en_out, digital_pd_out}), 16'h1, "gate");
      wait_rel();
      repeat (3) @(posedge mclk_in);
      rd(REG_STATUS, d);
      chk(16'(d[ST_CAUSE_LSB +: 3]), 16'(cz[k]), "cause");
      chk(16'(bc - b), (k == 4) ? 16'h0 : 16'h1, "boot");
      chk(16'(vcore_set_out), 16'(VCORE_DEF), "vcore reload");
      chk(16'(vana_set_out), 16'(VANA_DEF), "vana reload");
      chk(16'({clk_buf_en_out, digital_pd_out}), 16'h2, "ungate");
      chk(16'(regulator_en_out), 16'h1, "kept on");
    end
    $display("test sources done");
    // Every half step, then an out-of-range code
    for (int c = 0; c < 16; c++) begin
      wr(REG_CLK, 16'(c));
      chk(16'(pll_mult_out), (c < 15) ? 16'(c) : 16'he, "pll");
    end
    wr(REG_CTRL, 16'h2);
    @(posedge mclk_in);
    usb_suspend_in <= 1'b1;
    repeat (6) @(posedge mclk_in);
    chk(16'({clk_sel_rtc_out, osc_pd_out}), 16'h3, "suspend");
    usb_suspend_in <= 1'b0;
    repeat (6) @(posedge mclk_in);
    chk(16'({clk_sel_rtc_out, osc_pd_out}), 16'h0, "resume");
    $display("test clocks done");
    // Half a key does nothing; the full key powers off
    wr(REG_SHUTDOWN, 16'h1);
    chk(16'(regulator_en_out), 16'h1, "half key");
    wr(REG_SHUTDOWN, 16'h3);
    chk(16'(regulator_en_out), 16'h0, "shutdown");
    $display("test shutdown done");
    end_of_test();
  end
  // Tests take about 51k cycles; cut off at 80k
  initial begin
    #1600000;
    n_fail++;
    end_of_test();
  end
endmodule
bind rpbs_top rpbs_asserts i_rpbs_asserts (.*);
